// *** orc_pkg.sv ***
/*
  Shared constants and types of the output relay controller.
  Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none
package orc_pkg;
  // Clock and timing
  localparam int unsigned CLK_KHZ       = 10000;  // System clock in kHz
  localparam int unsigned TICK_MS       = 500;    // Delay step in ms
  localparam int unsigned TICK_CYCLES   = CLK_KHZ * TICK_MS;  // Cycles per step
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;  // Mode and trigger
  localparam logic [7:0] OFS_DELAY      = 8'h04;  // Transition delay
  localparam logic [7:0] OFS_MANUAL     = 8'h08;  // Manual relay command
  localparam logic [7:0] OFS_LIST       = 8'h0c;  // List relay command
  localparam logic [7:0] OFS_STATUS     = 8'h10;  // Live state
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h14;  // Sticky events
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;  // Event mask
  localparam logic [7:0] OFS_SECURE     = 8'h1c;  // Security clear
  // Field positions
  localparam int MODE_LSB               = 0;      // CTRL mode [1:0]
  localparam int TRIG_LSB               = 2;      // CTRL trigger [3:2]
  localparam int DELAY_W                = 9;      // Delay in half seconds
  localparam int IRQ_W                  = 3;      // Event count
  localparam int EV_RELAY_ON            = 0;      // Relay energized
  localparam int EV_RELAY_OFF           = 1;      // Relay released
  localparam int EV_DELAY_REJ           = 2;      // Delay write refused
  // Reset values and limits
  localparam logic [DELAY_W-1:0] DELAY_RST = 9'h002;  // One second
  localparam logic [DELAY_W-1:0] DELAY_MIN = 9'h001;  // Half a second
  localparam logic [DELAY_W-1:0] DELAY_MAX = 9'h100;  // 128 seconds
  localparam logic [1:0] RESP_OKAY      = 2'h0;   // AXI OKAY
  localparam logic [1:0] RESP_SLVERR    = 2'h2;   // AXI SLVERR
  // Relay mode
  typedef enum logic [1:0] {
    fault_driven_mode = 2'h0,
    manual_relay_mode = 2'h1,
    list_relay_mode   = 2'h2
  } orc_mode_t;
  // Fault sub-selection
  typedef enum logic [1:0] {
    any_fault_trigger = 2'h0,
    volt_to_curr_trig = 2'h1,
    curr_to_volt_trig = 2'h2
  } orc_trig_t;
  // Transition timing states
  typedef enum logic [2:0] {
    TR_IDLE    = 3'b001,
    TR_TIMING  = 3'b010,
    TR_TRIPPED = 3'b100
  } orc_tr_state_t;
  // Status from the supply core
  typedef struct packed {
    logic fault;      // Any system fault
    logic cc_reg;     // 1 constant current, 0 constant voltage
    logic out_en;     // Output enabled
  } orc_core_t;
endpackage : orc_pkg
`default_nettype wire

// *** orc_relay_ctrl.sv ***
/*
  Output relay controller: fault, manual and list modes behind AXI4-Lite.
  Assumes core status pins are asynchronous and are synchronised here.
*/
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none
module orc_relay_ctrl #(
  parameter int unsigned TICK_CYCLES = orc_pkg::TICK_CYCLES  // Cycles per half second
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Supply core status pins
  input  wire logic        fault_in,
  input  wire logic        cc_reg_in,
  input  wire logic        out_en_in,
  // Relay and interrupt
  output logic             relay_drive,
  output logic             irq
);

  // Merge a write word into a register under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : strb_merge

  // Pin synchronisers, two stages each
  orc_pkg::orc_core_t sync1_reg;      // First stage, read only by second
  orc_pkg::orc_core_t core_reg;       // Synchronised core status
  orc_pkg::orc_core_t core_d_reg;     // One cycle older, for edges

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_reg  <= '0;
      core_reg   <= '0;
      core_d_reg <= '0;
    end
    else
    begin
      sync1_reg  <= '{fault: fault_in, cc_reg: cc_reg_in, out_en: out_en_in};
      core_reg   <= sync1_reg;
      core_d_reg <= core_reg;
    end
  end

  // Bus capture state
  logic              aw_held_reg;     // Write address captured
  logic [7:0]        aw_addr_reg;     // Captured write address
  logic              w_held_reg;      // Write data captured
  logic [31:0]       w_data_reg;      // Captured write data
  logic [3:0]        w_strb_reg;      // Captured strobes
  logic              bvalid_reg;      // Write response pending
  logic [1:0]        bresp_reg;       // Write response code
  logic              rvalid_reg;      // Read data pending
  logic [31:0]       rdata_reg;       // Read data word
  logic [1:0]        rresp_reg;       // Read response code

  // Configuration and live state
  orc_pkg::orc_mode_t          mode_reg;      // Relay mode
  orc_pkg::orc_trig_t          trig_reg;      // Fault sub-selection
  logic [orc_pkg::DELAY_W-1:0] delay_reg;     // Delay in half seconds
  logic                        man_reg;       // Manual relay command
  logic                        list_reg;      // List relay command
  logic [orc_pkg::IRQ_W-1:0]   irq_stat_reg;  // Sticky events
  logic [orc_pkg::IRQ_W-1:0]   irq_mask_reg;  // Event mask
  orc_pkg::orc_tr_state_t      tr_state_reg;  // Transition timing state
  logic [22:0]                 pre_reg;       // Half-second prescaler
  logic [orc_pkg::DELAY_W-1:0] ticks_reg;     // Half seconds elapsed
  logic                        relay_reg;     // Relay drive
  logic                        irq_reg;       // Interrupt level

  // Write decode: a write fires when address and data are both held
  wire        wr_fire   = aw_held_reg && w_held_reg && !bvalid_reg;
  wire [31:0] wr_word   = w_data_reg;
  wire        wr_ctrl   = wr_fire && (aw_addr_reg == orc_pkg::OFS_CTRL);
  wire        wr_delay  = wr_fire && (aw_addr_reg == orc_pkg::OFS_DELAY);
  wire        wr_manual = wr_fire && (aw_addr_reg == orc_pkg::OFS_MANUAL);
  wire        wr_list   = wr_fire && (aw_addr_reg == orc_pkg::OFS_LIST);
  wire        wr_istat  = wr_fire && (aw_addr_reg == orc_pkg::OFS_IRQ_STAT);
  wire        wr_imask  = wr_fire && (aw_addr_reg == orc_pkg::OFS_IRQ_MASK);
  wire        wr_secure = wr_fire && (aw_addr_reg == orc_pkg::OFS_SECURE);
  wire        wr_ro     = wr_fire && (aw_addr_reg == orc_pkg::OFS_STATUS);
  wire        wr_hit    = wr_ctrl | wr_delay | wr_manual | wr_list |
                          wr_istat | wr_imask | wr_secure | wr_ro;

  // Strobed write values
  wire [31:0] ctrl_new  = strb_merge({28'h0000000, trig_reg, mode_reg}, wr_word, w_strb_reg);
  wire [31:0] delay_new = strb_merge({23'h000000, delay_reg}, wr_word, w_strb_reg);
  wire [31:0] man_new   = strb_merge({31'h00000000, man_reg}, wr_word, w_strb_reg);
  wire [31:0] list_new  = strb_merge({31'h00000000, list_reg}, wr_word, w_strb_reg);
  wire [31:0] clr_new   = strb_merge(32'h00000000, wr_word, w_strb_reg);
  wire [31:0] mask_new  = strb_merge({29'h00000000, irq_mask_reg}, wr_word, w_strb_reg);

  // Mode and trigger only accept their three encodings
  wire [1:0] mode_w   = ctrl_new[orc_pkg::MODE_LSB +: 2];
  wire [1:0] trig_w   = ctrl_new[orc_pkg::TRIG_LSB +: 2];
  wire       mode_ok  = (mode_w != 2'h3);
  wire       trig_ok  = (trig_w != 2'h3);
  wire       sec_clr  = wr_secure && clr_new[0];
  wire       cfg_chg  = sec_clr || (wr_ctrl && mode_ok && trig_ok &&
                        ((mode_w != mode_reg) || (trig_w != trig_reg)));

  // Delay range check; zero and above 128 s are refused
  wire [orc_pkg::DELAY_W-1:0] delay_w = delay_new[orc_pkg::DELAY_W-1:0];
  wire delay_ok  = (delay_new[31:orc_pkg::DELAY_W] == '0) &&
                   (delay_w >= orc_pkg::DELAY_MIN) &&
                   (delay_w <= orc_pkg::DELAY_MAX);
  wire delay_rej = wr_delay && !delay_ok;

  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg  <= orc_pkg::fault_driven_mode;
      trig_reg  <= orc_pkg::any_fault_trigger;
      delay_reg <= orc_pkg::DELAY_RST;
      man_reg   <= 1'b0;
      list_reg  <= 1'b0;
    end
    else
    begin
      if (sec_clr)
      begin
        mode_reg <= orc_pkg::fault_driven_mode;
        trig_reg <= orc_pkg::any_fault_trigger;
      end
      else if (wr_ctrl && mode_ok && trig_ok)
      begin
        mode_reg <= orc_pkg::orc_mode_t'(mode_w);
        trig_reg <= orc_pkg::orc_trig_t'(trig_w);
      end
      if (wr_delay && delay_ok)
      begin
        delay_reg <= delay_w;
      end
      if (wr_manual)
      begin
        man_reg <= man_new[0];
      end
      if (wr_list)
      begin
        list_reg <= list_new[0];
      end
    end
  end

  // Transition detection for the selected trigger
  wire in_new   = (trig_reg == orc_pkg::volt_to_curr_trig) ? core_reg.cc_reg
                                                           : !core_reg.cc_reg;
  wire was_old  = (trig_reg == orc_pkg::volt_to_curr_trig) ? !core_d_reg.cc_reg
                                                           : core_d_reg.cc_reg;
  wire trans_on = (mode_reg == orc_pkg::fault_driven_mode) &&
                  (trig_reg != orc_pkg::any_fault_trigger);
  wire entered  = trans_on && core_reg.out_en && in_new && was_old;
  wire tick     = (pre_reg == 23'(TICK_CYCLES - 1));
  wire expired  = tick && ((ticks_reg + 9'h001) >= delay_reg);
  wire leave    = !in_new || !core_reg.out_en;

  // Next transition state
  orc_pkg::orc_tr_state_t tr_next;
  always_comb
  begin
    tr_next = tr_state_reg;
    case (tr_state_reg)
      orc_pkg::TR_IDLE:
      begin
        if (entered)
        begin
          tr_next = orc_pkg::TR_TIMING;
        end
      end
      orc_pkg::TR_TIMING:
      begin
        if (leave)
        begin
          tr_next = orc_pkg::TR_IDLE;
        end
        else if (expired)
        begin
          tr_next = orc_pkg::TR_TRIPPED;
        end
      end
      orc_pkg::TR_TRIPPED:
      begin
        if (leave)
        begin
          tr_next = orc_pkg::TR_IDLE;
        end
      end
      default:
      begin
        tr_next = orc_pkg::TR_IDLE;
      end
    endcase
    if (cfg_chg || !trans_on)
    begin
      tr_next = orc_pkg::TR_IDLE;
    end
  end

  // Timing state, prescaler and tick count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tr_state_reg <= orc_pkg::TR_IDLE;
      pre_reg      <= '0;
      ticks_reg    <= '0;
    end
    else
    begin
      tr_state_reg <= tr_next;
      if (tr_next != orc_pkg::TR_TIMING || tr_state_reg != orc_pkg::TR_TIMING)
      begin
        pre_reg   <= '0;
        ticks_reg <= '0;
      end
      else if (tick)
      begin
        pre_reg   <= '0;
        ticks_reg <= ticks_reg + 9'h001;
      end
      else
      begin
        pre_reg <= pre_reg + 23'h000001;
      end
    end
  end

  // Relay drive chosen by mode
  wire fault_drive = core_reg.fault ||
                     (tr_state_reg == orc_pkg::TR_TRIPPED);
  logic relay_next;
  always_comb
  begin
    case (mode_reg)
      orc_pkg::fault_driven_mode: relay_next = fault_drive;
      orc_pkg::manual_relay_mode: relay_next = man_reg;
      orc_pkg::list_relay_mode:   relay_next = list_reg;
      default:                    relay_next = 1'b0;
    endcase
  end

  // Events: relay on, relay off, refused delay
  wire [orc_pkg::IRQ_W-1:0] ev_set;
  assign ev_set[orc_pkg::EV_RELAY_ON]  = relay_next && !relay_reg;
  assign ev_set[orc_pkg::EV_RELAY_OFF] = !relay_next && relay_reg;
  assign ev_set[orc_pkg::EV_DELAY_REJ] = delay_rej;
  wire [orc_pkg::IRQ_W-1:0] ev_clr = wr_istat ? clr_new[orc_pkg::IRQ_W-1:0] : '0;
  wire [orc_pkg::IRQ_W-1:0] stat_next = (irq_stat_reg & ~ev_clr) | ev_set;

  // Relay, sticky status and interrupt
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      relay_reg    <= 1'b0;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg      <= 1'b0;
    end
    else
    begin
      relay_reg    <= relay_next;
      irq_stat_reg <= stat_next;
      if (wr_imask)
      begin
        irq_mask_reg <= mask_new[orc_pkg::IRQ_W-1:0];
      end
      irq_reg <= |(stat_next & (wr_imask ? mask_new[orc_pkg::IRQ_W-1:0] : irq_mask_reg));
    end
  end

  // Read decode
  wire [7:0] ra = s_axi_araddr;
  wire [31:0] status_word = {27'h0000000, (tr_state_reg == orc_pkg::TR_TIMING),
                             core_reg.out_en, core_reg.cc_reg, core_reg.fault,
                             relay_reg};
  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    case (ra)
      orc_pkg::OFS_CTRL:     rd_word = {28'h0000000, trig_reg, mode_reg};
      orc_pkg::OFS_DELAY:    rd_word = {23'h000000, delay_reg};
      orc_pkg::OFS_MANUAL:   rd_word = {31'h00000000, man_reg};
      orc_pkg::OFS_LIST:     rd_word = {31'h00000000, list_reg};
      orc_pkg::OFS_STATUS:   rd_word = status_word;
      orc_pkg::OFS_IRQ_STAT: rd_word = {29'h00000000, irq_stat_reg};
      orc_pkg::OFS_IRQ_MASK: rd_word = {29'h00000000, irq_mask_reg};
      orc_pkg::OFS_SECURE:   rd_word = 32'h00000000;
      default:
      begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b0;
      end
    endcase
  end
  wire rd_take = s_axi_arvalid && s_axi_arready;

  // Write channel handshakes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= orc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? orc_pkg::RESP_OKAY : orc_pkg::RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg  <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
      end
    end
  end

  // Read channel handshakes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= orc_pkg::RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? orc_pkg::RESP_OKAY : orc_pkg::RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  // Ready flags are registered so every output comes from a flop
  logic awready_reg;
  logic wready_reg;
  logic arready_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      arready_reg <= 1'b0;
    end
    else
    begin
      awready_reg <= !(aw_held_reg || (s_axi_awvalid && awready_reg)) ||
                     (bvalid_reg && s_axi_bready);
      wready_reg  <= !(w_held_reg || (s_axi_wvalid && wready_reg)) ||
                     (bvalid_reg && s_axi_bready);
      arready_reg <= !rvalid_reg && !(s_axi_arvalid && arready_reg);
    end
  end

  // Output wiring
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign relay_drive   = relay_reg;
  assign irq           = irq_reg;

endmodule : orc_relay_ctrl
`default_nettype wire

// *** orc_relay_ctrl_assertions.sv ***
/*
  Checker for the output relay controller ports.
  Assumes the master offers write address and data in the same cycle.
*/
`default_nettype none
module orc_relay_ctrl_assertions (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Status and relay
  input wire logic        fault_in,
  input wire logic        relay_drive,
  input wire logic        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic wr_fire;         // Both write channels taken
  logic ctrl_ok;         // Legal control value
  logic fault_mode_reg;  // Shadow of fault mode
  assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign ctrl_ok = (s_axi_wdata[1:0] != 2'h3) && (s_axi_wdata[3:2] != 2'h3);
  // Follow mode writes and security clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fault_mode_reg <= 1'b1;
    else if (wr_fire && s_axi_awaddr == orc_pkg::OFS_CTRL && ctrl_ok)
      fault_mode_reg <= (s_axi_wdata[1:0] == 2'h0);
    else if (wr_fire && s_axi_awaddr == orc_pkg::OFS_SECURE && s_axi_wdata[0])
      fault_mode_reg <= 1'b1;
  end
  property p_aw_drop;
    wr_fire |=> (!s_axi_awready && !s_axi_wready)[*2];
  endproperty
  a_aw_drop: assert property (p_aw_drop) else $error("write readies not dropped");
  property p_b_time;
    wr_fire |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write response late");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response repeated");
  property p_r_time;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_time: assert property (p_r_time) else $error("read data late");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read data repeated");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_reset_off;
    $rose(aresetn) |-> !relay_drive && !irq && !s_axi_bvalid;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("outputs set after reset");
  property p_fault_relay;
    (fault_mode_reg && fault_in)[*5] |-> relay_drive;
  endproperty
  a_fault_relay: assert property (p_fault_relay) else $error("fault not on relay");
endmodule : orc_relay_ctrl_assertions
bind orc_relay_ctrl orc_relay_ctrl_assertions orc_relay_ctrl_assertions_i (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .fault_in, .relay_drive, .irq);
`default_nettype wire

// *** orc_supply_model.sv ***
/*
  Supply core model: fault, regulation and output enable levels.
  Assumes the bench calls set_core between clock edges.
*/
`default_nettype none
module orc_supply_model (
  // Clock
  input wire logic aclk,
  // Core status pins
  output var logic fault_in,
  output var logic cc_reg_in,
  output var logic out_en_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Healthy, voltage regulated, output on
  initial
  begin
    fault_in = 1'b0;
    cc_reg_in = 1'b0;
    out_en_in = 1'b1;
  end
  // Change all levels just after an edge
  task automatic set_core(input logic f, input logic c, input logic e);
    @(posedge aclk);
    fault_in <= f;
    cc_reg_in <= c;
    out_en_in <= e;
  endtask : set_core
endmodule : orc_supply_model
`default_nettype wire

// *** tb_orc_relay_ctrl.sv ***
/*
  Self-checking bench of the output relay controller.
  Assumes a shortened half-second step of TICKS cycles.
*/
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %h want %h", $time, (a), (b)); end end
module tb_orc_relay_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TICKS = 10;  // Short half-second step
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, fault_in, cc_reg_in, out_en_in, relay_drive, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int errors, samples_checked, cycles;
  orc_relay_ctrl #(.TICK_CYCLES(TICKS)) orc_relay_ctrl_i (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .fault_in,
    .cc_reg_in, .out_en_in, .relay_drive, .irq);
  orc_supply_model orc_supply_model_i (.aclk, .fault_in, .cc_reg_in, .out_en_in);
  // Free-running system clock
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Cut a hang short
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle
  // One write; both channels offered at once, response compared
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1)
      begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1)
      begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    `CHK(s_axi_bresp, er)
    s_axi_bready <= 1'b0;
  endtask : wr
  // One read; masked data and response compared
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    `CHK(s_axi_rdata & m, e)
    `CHK(s_axi_rresp, er)
    s_axi_rready <= 1'b0;
  endtask : rd
  // Bounded wait for a relay level
  task automatic wait_relay(input logic v, input int n);
    for (int i = 0; i < n && relay_drive !== v; i++) @(posedge aclk);
    `CHK(relay_drive, v)
  endtask : wait_relay
  task automatic t_defaults();
    rd(orc_pkg::OFS_CTRL, 32'h0, 32'hf, orc_pkg::RESP_OKAY);
    rd(orc_pkg::OFS_DELAY, 32'h2, 32'h1ff, orc_pkg::RESP_OKAY);
    rd(orc_pkg::OFS_STATUS, 32'h0, 32'h1, orc_pkg::RESP_OKAY);
    rd(8'h20, 32'h0, 32'hffffffff, orc_pkg::RESP_SLVERR);
  endtask : t_defaults
  task automatic t_fault();
    orc_supply_model_i.set_core(1'b1, 1'b0, 1'b1);
    wait_relay(1'b1, 4);
    rd(orc_pkg::OFS_STATUS, 32'h1, 32'h1, orc_pkg::RESP_OKAY);
    orc_supply_model_i.set_core(1'b0, 1'b0, 1'b1);
    wait_relay(1'b0, 4);
  endtask : t_fault
  task automatic t_delay();
    wr(orc_pkg::OFS_DELAY, 32'h0, orc_pkg::RESP_OKAY);
    rd(orc_pkg::OFS_DELAY, 32'h2, 32'h1ff, orc_pkg::RESP_OKAY);
    rd(orc_pkg::OFS_IRQ_STAT, 32'h4, 32'h4, orc_pkg::RESP_OKAY);
    wr(orc_pkg::OFS_DELAY, 32'h101, orc_pkg::RESP_OKAY);
    rd(orc_pkg::OFS_DELAY, 32'h2, 32'h1ff, orc_pkg::RESP_OKAY);
    wr(orc_pkg::OFS_DELAY, 32'h100, orc_pkg::RESP_OKAY);
    rd(orc_pkg::OFS_DELAY, 32'h100, 32'h1ff, orc_pkg::RESP_OKAY);
    wr(orc_pkg::OFS_DELAY, 32'h1, orc_pkg::RESP_OKAY);
    rd(orc_pkg::OFS_DELAY, 32'h1, 32'h1ff, orc_pkg::RESP_OKAY);
  endtask : t_delay
  // Delay is one step of TICKS cycles from here until the re-reset
  task automatic t_v2c();
    wr(orc_pkg::OFS_CTRL, 32'h4, orc_pkg::RESP_OKAY);
    orc_supply_model_i.set_core(1'b1, 1'b0, 1'b1);
    wait_relay(1'b1, 4);
    orc_supply_model_i.set_core(1'b0, 1'b0, 1'b1);
    wait_relay(1'b0, 4);
    orc_supply_model_i.set_core(1'b0, 1'b1, 1'b1);
    idle(8);
    `CHK(relay_drive, 1'b0)
    orc_supply_model_i.set_core(1'b0, 1'b0, 1'b1);
    idle(4);
    orc_supply_model_i.set_core(1'b0, 1'b1, 1'b1);
    idle(8);
    `CHK(relay_drive, 1'b0)
    wait_relay(1'b1, 12);
    orc_supply_model_i.set_core(1'b0, 1'b0, 1'b1);
    wait_relay(1'b0, 6);
  endtask : t_v2c
  task automatic t_c2v();
    orc_supply_model_i.set_core(1'b0, 1'b1, 1'b1);
    wr(orc_pkg::OFS_CTRL, 32'h8, orc_pkg::RESP_OKAY);
    idle(14);
    `CHK(relay_drive, 1'b0)
    orc_supply_model_i.set_core(1'b0, 1'b0, 1'b1);
    wait_relay(1'b1, 16);
    orc_supply_model_i.set_core(1'b0, 1'b0, 1'b0);
    wait_relay(1'b0, 6);
    orc_supply_model_i.set_core(1'b0, 1'b0, 1'b1);
  endtask : t_c2v
  task automatic t_manual_list();
    wr(orc_pkg::OFS_IRQ_MASK, 32'h1, orc_pkg::RESP_OKAY);
    wr(orc_pkg::OFS_IRQ_STAT, 32'h7, orc_pkg::RESP_OKAY);
    wr(orc_pkg::OFS_CTRL, 32'h1, orc_pkg::RESP_OKAY);
    wr(orc_pkg::OFS_MANUAL, 32'h1, orc_pkg::RESP_OKAY);
    wait_relay(1'b1, 2);
    idle(2);
    `CHK(irq, 1'b1)
    wr(orc_pkg::OFS_IRQ_STAT, 32'h1, orc_pkg::RESP_OKAY);
    idle(2);
    `CHK(irq, 1'b0)
    wr(orc_pkg::OFS_MANUAL, 32'h0, orc_pkg::RESP_OKAY);
    wait_relay(1'b0, 2);
    idle(2);
    `CHK(irq, 1'b0)
    rd(orc_pkg::OFS_IRQ_STAT, 32'h2, 32'h3, orc_pkg::RESP_OKAY);
    wr(orc_pkg::OFS_CTRL, 32'h2, orc_pkg::RESP_OKAY);
    wr(orc_pkg::OFS_LIST, 32'h1, orc_pkg::RESP_OKAY);
    wait_relay(1'b1, 2);
    rd(orc_pkg::OFS_STATUS, 32'h1, 32'h1, orc_pkg::RESP_OKAY);
    wr(orc_pkg::OFS_LIST, 32'h0, orc_pkg::RESP_OKAY);
    wait_relay(1'b0, 2);
  endtask : t_manual_list
  task automatic t_secure();
    wr(orc_pkg::OFS_CTRL, 32'h9, orc_pkg::RESP_OKAY);
    wr(orc_pkg::OFS_CTRL, 32'h3, orc_pkg::RESP_OKAY);
    rd(orc_pkg::OFS_CTRL, 32'h9, 32'hf, orc_pkg::RESP_OKAY);
    wr(orc_pkg::OFS_SECURE, 32'h1, orc_pkg::RESP_OKAY);
    rd(orc_pkg::OFS_CTRL, 32'h0, 32'hf, orc_pkg::RESP_OKAY);
  endtask : t_secure
  task automatic t_rereset();
    wr(orc_pkg::OFS_CTRL, 32'h1, orc_pkg::RESP_OKAY);
    wr(orc_pkg::OFS_MANUAL, 32'h1, orc_pkg::RESP_OKAY);
    wait_relay(1'b1, 2);
    aresetn <= 1'b0;
    idle(3);
    aresetn <= 1'b1;
    idle(1);
    `CHK(relay_drive, 1'b0)
    rd(orc_pkg::OFS_MANUAL, 32'h0, 32'h1, orc_pkg::RESP_OKAY);
    rd(orc_pkg::OFS_DELAY, 32'h2, 32'h1ff, orc_pkg::RESP_OKAY);
  endtask : t_rereset
  // Main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    idle(1);
    t_defaults();
    t_fault();
    t_delay();
    t_v2c();
    t_c2v();
    t_manual_list();
    t_secure();
    t_rereset();
    complete_run();
  end
endmodule : tb_orc_relay_ctrl
`default_nettype wire
